/* File: logic/cis_pkg.sv */
// package: constants for the interrupt sequencer
`default_nettype none
package cis_pkg;
	localparam logic [5:0] IO_SP_LOW = 6'h3d;
	localparam logic [5:0] IO_SP_HIGH = 6'h3e;
	localparam logic [5:0] IO_STATUS = 6'h3f;
	localparam int BIT_GIE = 7;
	localparam int BIT_T = 6;
	localparam int BIT_H = 5;
	localparam int BIT_S = 4;
	localparam int BIT_V = 3;
	localparam int BIT_N = 2;
	localparam int BIT_Z = 1;
	localparam int BIT_C = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] TOP_OF_RAM = 16'h015f;
	localparam int ENTRY_CYCLES = 4;
	localparam int RETURN_CYCLES = 4;
	localparam int SLEEP_EXTRA_CYCLES = 4;
	localparam logic [15:0] RET_ADDR_BYTES = 16'h0002;
	localparam logic [2:0] SEQ_CNT_ONE = 3'h1;
	typedef enum logic [1:0] {
		CIS_RUN = 2'b00,
		CIS_WAKE = 2'b01,
		CIS_ENTRY = 2'b10,
		CIS_RETURN = 2'b11
	} cis_state_t;
endpackage
`default_nettype wire

/* File: logic/cis_arbiter.sv */
// fixed priority picker: lowest index wins
`default_nettype none
module cis_arbiter #(
	parameter int N = 8
) (
	input wire logic [N-1:0] req,
	output logic found,
	output logic [$clog2(N)-1:0] index
);
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = i[$clog2(N)-1:0];
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/cis_sequencer.sv */
// interrupt entry/return sequencer with stack pointer and status register
// Contract
// RL1 - undivided core clock, fetch overlaps execute
// RL2 - take source only with local and global enable
// RL3 - lower vector index wins arbitration
// RL4 - entry clears global enable
// RL5 - return sets global enable
// RL6 - vectoring or write-one clears flag
// RL7 - masked flags held until served
// RL8 - level sources never remembered
// RL9 - one instruction after return before next
// RL10 - status never saved or restored automatically
// RL11 - disable takes effect in same cycle
// RL12 - one instruction after enable before service
// RL13 - entry four cycles, pushes program counter
// RL14 - wait for multi-cycle instruction end
// RL15 - sleeping adds four cycles after wake-up
// RL16 - return four cycles, pops, sp plus two
// RL17 - sixteen-bit stack pointer at 0x3E/0x3D
// RL18 - status bit layout, enable at bit 7
// RL19 - sign equals negative xor overflow
// RL20 - push decrements stack pointer by two
`default_nettype none
module cis_sequencer #(
	parameter int NSRC = 8,
	parameter logic [NSRC-1:0] LEVEL_TYPE = 8'h00,
	parameter logic [15:0] SP_INIT = cis_pkg::TOP_OF_RAM
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NSRC-1:0] src_event,
	input wire logic [NSRC-1:0] src_enable,
	input wire logic instr_boundary,
	input wire logic instr_done,
	input wire logic instr_enable_irq,
	input wire logic instr_disable_irq,
	input wire logic instr_return_irq,
	input wire logic instr_call,
	input wire logic instr_ret,
	input wire logic sleeping,
	input wire logic wake_ready,
	input wire logic [6:0] alu_flags,
	input wire logic alu_flags_we,
	input wire logic io_we,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [NSRC-1:0] flag_clear_w1,
	output logic [7:0] io_rdata,
	output logic [NSRC-1:0] flags_out,
	output logic [15:0] stack_pointer,
	output logic [7:0] status_flags,
	output logic irq_take,
	output logic [$clog2(NSRC)-1:0] vector_index,
	output logic core_hold
);
	// =====================================================
	// input synchronisers for peripheral event pins
	logic [NSRC-1:0] ev_s1_reg, ev_s2_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ev_s1_reg <= '0;
			ev_s2_reg <= '0;
		end else begin
			ev_s1_reg <= src_event;
			ev_s2_reg <= ev_s1_reg;
		end
	end

	// =====================================================
	// state
	cis_pkg::cis_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [NSRC-1:0] flag_reg, flag_next;
	logic [15:0] sp_reg, sp_next;
	logic [7:0] sr_reg, sr_next;
	logic hold_reg, hold_next;
	logic take_reg, take_next;
	logic [$clog2(NSRC)-1:0] vec_reg, vec_next;
	logic block_reg, block_next;
	logic [$clog2(NSRC)-1:0] win_idx;
	logic win_found;
	logic [NSRC-1:0] pend;
	logic gie_eff;
	localparam logic [2:0] SEQ_ONE = cis_pkg::SEQ_CNT_ONE;

	// masked flags keep their value; level sources follow the pin only
	assign pend = ((flag_reg & ~LEVEL_TYPE) | (ev_s2_reg & LEVEL_TYPE)) & src_enable; // RL2 RL7 RL8
	// disable in this same cycle already blocks acceptance
	assign gie_eff = sr_reg[cis_pkg::BIT_GIE] & ~instr_disable_irq; // RL11

	cis_arbiter #(.N(NSRC)) u_arb (
		.req(pend),
		.found(win_found),
		.index(win_idx)
	); // RL3

	// =====================================================
	// next state
	always_comb begin
		logic accept;
		accept = 1'b0;
		state_next = state_reg;
		cnt_next = cnt_reg;
		sp_next = sp_reg;
		sr_next = sr_reg;
		hold_next = hold_reg;
		take_next = 1'b0;
		vec_next = vec_reg;
		block_next = block_reg;
		// edge flags: hardware set wins over a write-one clear
		flag_next = (flag_reg & ~flag_clear_w1) | (ev_s2_reg & ~LEVEL_TYPE); // RL6 RL7
		// flags written by the alu; sign is always derived
		if (alu_flags_we) begin
			sr_next[6:0] = alu_flags;
		end
		if (io_we && io_addr == cis_pkg::IO_STATUS) begin
			sr_next = io_wdata;
		end
		if (io_we && io_addr == cis_pkg::IO_SP_LOW) begin
			sp_next[7:0] = io_wdata; // RL17
		end
		if (io_we && io_addr == cis_pkg::IO_SP_HIGH) begin
			sp_next[15:8] = io_wdata; // RL17
		end
		unique case (state_reg)
			cis_pkg::CIS_RUN: begin
				if (instr_done) begin
					block_next = 1'b0;
				end
				if (instr_enable_irq) begin
					sr_next[cis_pkg::BIT_GIE] = 1'b1;
					block_next = 1'b1; // RL12
				end
				if (instr_disable_irq) begin
					sr_next[cis_pkg::BIT_GIE] = 1'b0; // RL11
				end
				if (instr_call) begin
					sp_next = sp_reg - cis_pkg::RET_ADDR_BYTES; // RL20
				end
				if (instr_ret) begin
					sp_next = sp_reg + cis_pkg::RET_ADDR_BYTES;
				end
				accept = gie_eff && win_found && !block_reg && !instr_enable_irq
					&& (instr_boundary || sleeping); // RL2 RL9 RL12 RL14
				if (instr_return_irq) begin
					state_next = cis_pkg::CIS_RETURN;
					cnt_next = 3'(cis_pkg::RETURN_CYCLES - 1);
					hold_next = 1'b1;
				end else if (accept) begin
					vec_next = win_idx;
					take_next = 1'b1;
					hold_next = 1'b1;
					sr_next[cis_pkg::BIT_GIE] = 1'b0; // RL4
					// a new edge in the same cycle keeps the flag: set wins
					flag_next[win_idx] = ev_s2_reg[win_idx] & ~LEVEL_TYPE[win_idx]; // RL6
					if (sleeping) begin
						state_next = cis_pkg::CIS_WAKE; // RL15
						cnt_next = 3'(cis_pkg::SLEEP_EXTRA_CYCLES);
					end else begin
						state_next = cis_pkg::CIS_ENTRY; // RL13
						cnt_next = 3'(cis_pkg::ENTRY_CYCLES);
					end
				end
			end
			cis_pkg::CIS_WAKE: begin
				// extra four cycles count only once the clock source is up
				if (wake_ready) begin
					if (cnt_reg == SEQ_ONE) begin
						state_next = cis_pkg::CIS_ENTRY; // RL15
						cnt_next = 3'(cis_pkg::ENTRY_CYCLES);
					end else begin
						cnt_next = cnt_reg - SEQ_ONE;
					end
				end
			end
			cis_pkg::CIS_ENTRY: begin
				// push of the two-byte return address
				// all four entry cycles are held; the accept cycle belongs to the old instruction
				if (cnt_reg == 3'(cis_pkg::ENTRY_CYCLES)) begin
					sp_next = sp_reg - cis_pkg::RET_ADDR_BYTES; // RL13 RL20
				end
				if (cnt_reg == SEQ_ONE) begin
					state_next = cis_pkg::CIS_RUN;
					hold_next = 1'b0;
				end else begin
					cnt_next = cnt_reg - SEQ_ONE;
				end
			end
			cis_pkg::CIS_RETURN: begin
				if (cnt_reg == SEQ_ONE) begin
					state_next = cis_pkg::CIS_RUN;
					hold_next = 1'b0;
					// status flags other than enable are left untouched
					sp_next = sp_reg + cis_pkg::RET_ADDR_BYTES; // RL16 RL10
					sr_next[cis_pkg::BIT_GIE] = 1'b1; // RL5 RL16
					block_next = 1'b1; // RL9
				end else begin
					cnt_next = cnt_reg - SEQ_ONE;
				end
			end
		endcase
		sr_next[cis_pkg::BIT_S] = sr_next[cis_pkg::BIT_N] ^ sr_next[cis_pkg::BIT_V]; // RL19 RL18
	end

	// =====================================================
	// registers; single clock, no divider or enable
	always_ff @(posedge clk or posedge rst) begin // RL1
		if (rst) begin
			state_reg <= cis_pkg::CIS_RUN;
			cnt_reg <= 3'h0;
			flag_reg <= '0;
			sp_reg <= SP_INIT; // RL17
			sr_reg <= cis_pkg::STATUS_RESET;
			hold_reg <= 1'b0;
			take_reg <= 1'b0;
			vec_reg <= '0;
			block_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			flag_reg <= flag_next;
			sp_reg <= sp_next;
			sr_reg <= sr_next;
			hold_reg <= hold_next;
			take_reg <= take_next;
			vec_reg <= vec_next;
			block_reg <= block_next;
		end
	end

	// =====================================================
	// read path, registered
	logic [7:0] rdata_reg, rdata_next;
	always_comb begin
		rdata_next = 8'h00;
		if (io_addr == cis_pkg::IO_SP_LOW) begin
			rdata_next = sp_reg[7:0];
		end else if (io_addr == cis_pkg::IO_SP_HIGH) begin
			rdata_next = sp_reg[15:8];
		end else if (io_addr == cis_pkg::IO_STATUS) begin
			rdata_next = sr_reg;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign io_rdata = rdata_reg;
	assign flags_out = flag_reg;
	assign stack_pointer = sp_reg;
	assign status_flags = sr_reg;
	assign irq_take = take_reg;
	assign vector_index = vec_reg;
	assign core_hold = hold_reg;

	// =====================================================
	// checks
	a_cli_blocks_take: assert property (@(posedge clk) disable iff (rst) // RL11
		instr_disable_irq |=> !take_reg)
		else $error("take after disable");
	a_take_clears_gie: assert property (@(posedge clk) disable iff (rst) // RL4
		$rose(take_reg) |-> !sr_reg[cis_pkg::BIT_GIE])
		else $error("gie kept on entry");
	a_take_needs_gie: assert property (@(posedge clk) disable iff (rst) // RL2
		$rose(take_reg) |-> $past(sr_reg[cis_pkg::BIT_GIE]))
		else $error("take without gie");
	a_entry_sp_down: assert property (@(posedge clk) disable iff (rst) // RL20
		(take_reg && state_reg == cis_pkg::CIS_ENTRY && !io_we) |=> sp_reg == $past(sp_reg) - 16'h0002)
		else $error("entry push wrong");
	a_entry_length: assert property (@(posedge clk) disable iff (rst) // RL13
		(take_reg && state_reg == cis_pkg::CIS_ENTRY) |-> core_hold [*4] ##1 !core_hold)
		else $error("entry not four cycles");
	a_return_sets_gie: assert property (@(posedge clk) disable iff (rst) // RL5
		(state_reg == cis_pkg::CIS_RUN && instr_return_irq) |-> ##4 sr_reg[cis_pkg::BIT_GIE])
		else $error("return left gie clear");
	a_return_block: assert property (@(posedge clk) disable iff (rst) // RL9
		(state_reg == cis_pkg::CIS_RETURN && cnt_reg == SEQ_ONE) |=> ##1 !take_reg)
		else $error("no instruction after return");
	a_sign_xor: assert property (@(posedge clk) disable iff (rst) // RL19
		sr_reg[cis_pkg::BIT_S] == (sr_reg[cis_pkg::BIT_N] ^ sr_reg[cis_pkg::BIT_V]))
		else $error("sign flag wrong");
	a_sei_delay: assert property (@(posedge clk) disable iff (rst) // RL12
		instr_enable_irq |=> !take_reg)
		else $error("take right after enable");
	a_ret_sp_up: assert property (@(posedge clk) disable iff (rst) // RL16
		(state_reg == cis_pkg::CIS_RETURN && cnt_reg == SEQ_ONE) |=> sp_reg == $past(sp_reg) + 16'h0002)
		else $error("return pop wrong");
	a_level_unlatched: assert property (@(posedge clk) disable iff (rst) // RL8
		(flag_reg & LEVEL_TYPE) == '0)
		else $error("level source remembered");
	a_take_pulse: assert property (@(posedge clk) disable iff (rst) // RL13
		take_reg |=> !take_reg)
		else $error("take longer than one cycle");
	a_wake_holds: assert property (@(posedge clk) disable iff (rst) // RL15
		state_reg == cis_pkg::CIS_WAKE |-> core_hold)
		else $error("core runs during wake count");
	a_cli_clears_gie: assert property (@(posedge clk) disable iff (rst) // RL11
		(state_reg == cis_pkg::CIS_RUN && instr_disable_irq && !io_we) |=> !sr_reg[cis_pkg::BIT_GIE])
		else $error("disable left gie set");
	a_sei_sets_gie: assert property (@(posedge clk) disable iff (rst) // RL12
		(state_reg == cis_pkg::CIS_RUN && instr_enable_irq && !instr_disable_irq && !io_we) |=> sr_reg[cis_pkg::BIT_GIE])
		else $error("enable left gie clear");
	a_take_boundary: assert property (@(posedge clk) disable iff (rst) // RL14
		$rose(take_reg) |-> $past(instr_boundary || sleeping))
		else $error("take inside an instruction");
	a_status_kept: assert property (@(posedge clk) disable iff (rst) // RL10
		(take_reg && $past(!alu_flags_we && !io_we)) |-> sr_reg[6:0] == $past(sr_reg[6:0]))
		else $error("status changed on entry");
endmodule
`default_nettype wire

/* File: testbench/cis_pipe_model.sv */
// pipeline model: drives instruction boundary and completion pulses
`default_nettype none
module cis_pipe_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_hold,
	input wire logic slow,
	output logic instr_boundary,
	output logic instr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic phase;
	// =====================
	// issue
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			phase <= 1'b0;
			instr_boundary <= 1'b0;
			instr_done <= 1'b0;
		end else if (core_hold) begin
			instr_boundary <= 1'b0;
			instr_done <= 1'b0;
		end else if (slow && !phase) begin
			// two-cycle instruction: no boundary in its first half
			phase <= 1'b1;
			instr_boundary <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			phase <= 1'b0;
			instr_boundary <= 1'b1;
			instr_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/cpu_interrupt_sequencer_bench.sv */
// self-checking bench for the interrupt sequencer
`default_nettype none
module cpu_interrupt_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, bnd, done, en_p, dis_p, ret_p, call_p, rtn_p, alu_we, io_we, take, hold, slow, sleep, wake;
	logic [7:0] ev, en, clr, rdata, flags, status, wdata, r;
	logic [6:0] alu;
	logic [5:0] addr;
	logic [15:0] sp, sp1;
	logic [2:0] vec;
	logic [31:0] seed, x;
	int bad_count, checks_done, takes, n;
	// =====================
	// design and pipeline
	// source 6 is level type so both request kinds are exercised
	cis_sequencer #(.LEVEL_TYPE(8'h40)) u_dut (.clk(clk), .rst(rst), .src_event(ev), .src_enable(en),
		.instr_boundary(bnd), .instr_done(done), .instr_enable_irq(en_p),
		.instr_disable_irq(dis_p), .instr_return_irq(ret_p), .instr_call(call_p),
		.instr_ret(rtn_p), .sleeping(sleep), .wake_ready(wake), .alu_flags(alu),
		.alu_flags_we(alu_we), .io_we(io_we), .io_addr(addr), .io_wdata(wdata),
		.flag_clear_w1(clr), .io_rdata(rdata), .flags_out(flags), .stack_pointer(sp),
		.status_flags(status), .irq_take(take), .vector_index(vec), .core_hold(hold));
	cis_pipe_model u_pipe (.clk(clk), .rst(rst), .core_hold(hold), .slow(slow),
		.instr_boundary(bnd), .instr_done(done));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) if (take === 1'b1) takes++;
	// =====================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	task automatic io_wr(logic [5:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		io_we = 1'b1;
		tick(1);
		io_we = 1'b0;
		tick(1);
	endtask
	task automatic io_rd(logic [5:0] a);
		addr = a;
		tick(1);
		r = rdata;
	endtask
	// entry then return; the status low bits must pass through untouched
	task automatic serve(logic [2:0] k);
		logic [15:0] sp0;
		logic [6:0] s0;
		int i;
		sp0 = sp;
		s0 = status[6:0];
		i = 0;
		while (take !== 1'b1 && i < 40) begin
			tick(1);
			i++;
		end
		ev = 8'h00;
		if (i == 40) begin
			bad_count++;
			return;
		end
		chk("vector", vec, k);
		chk("gie_entry", status[7], 1'b0);
		chk("flag_clr", flags[k], 1'b0);
		tick(3);
		chk("hold", hold, 1'b1);
		tick(1);
		chk("hold_end", hold, 1'b0);
		chk("sp_push", sp, sp0 - cis_pkg::RET_ADDR_BYTES);
		ret_p = 1'b1;
		tick(1);
		ret_p = 1'b0;
		tick(2);
		chk("ret_hold", hold, 1'b1);
		tick(1);
		chk("ret_hold_end", hold, 1'b0);
		chk("sp_pop", sp, sp0);
		chk("gie_ret", status[7], 1'b1);
		chk("status_kept", status[6:0], s0);
	endtask
	// =====================
	// main sequence
	initial begin
		{en_p, dis_p, ret_p, call_p, rtn_p, alu_we, io_we, slow, sleep} = 9'h000;
		wake = 1'b1;
		{ev, clr, wdata, alu, addr} = 37'h0;
		en = 8'h7f;
		seed = 32'h0000_0011;
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		chk("sp_rst", sp, cis_pkg::TOP_OF_RAM);
		chk("status_rst", status, cis_pkg::STATUS_RESET);
		io_rd(cis_pkg::IO_SP_LOW);
		chk("sp_low_rst", r, cis_pkg::TOP_OF_RAM[7:0]);
		x = xs();
		io_wr(cis_pkg::IO_SP_HIGH, x[15:8]);
		io_wr(cis_pkg::IO_SP_LOW, x[7:0]);
		chk("sp_rw", sp, x[15:0]);
		io_rd(cis_pkg::IO_SP_HIGH);
		chk("sp_high", r, x[15:8]);
		call_p = 1'b1;
		tick(1);
		call_p = 1'b0;
		tick(1);
		chk("call_push", sp, x[15:0] - cis_pkg::RET_ADDR_BYTES);
		rtn_p = 1'b1;
		tick(1);
		rtn_p = 1'b0;
		tick(1);
		chk("ret_pop", sp, x[15:0]);
		$display("test stack pointer done");
		repeat (8) begin
			x = xs();
			alu = x[6:0];
			alu_we = 1'b1;
			tick(1);
			alu_we = 1'b0;
			tick(1);
			chk("sign", status[4], x[2] ^ x[3]);
			chk("flags_low", {status[6:5], status[3:0]}, {x[6:5], x[3:0]});
		end
		$display("test flags done");
		io_wr(cis_pkg::IO_STATUS, 8'h80);
		chk("gie_set", status[7], 1'b1);
		io_rd(cis_pkg::IO_STATUS);
		chk("status_rd", r, 8'h80);
		// source 6 is level type and would vanish before a slow boundary
		x = xs() % 6;
		slow = 1'b1;
		ev[x[2:0]] = 1'b1;
		tick(1);
		ev = 8'h00;
		serve(x[2:0]);
		slow = 1'b0;
		$display("test random entry done");
		io_wr(cis_pkg::IO_STATUS, 8'h00);
		ev = 8'hac;
		tick(1);
		ev = 8'h00;
		tick(6);
		chk("masked", takes, 1);
		chk("held", {flags[7], flags[5], flags[3], flags[2]}, 4'hf);
		clr = 8'h08;
		tick(1);
		clr = 8'h00;
		tick(1);
		chk("w1_clear", flags[3], 1'b0);
		en_p = 1'b1;
		tick(1);
		en_p = 1'b0;
		tick(1);
		chk("sei_gap", take, 1'b0);
		serve(3'h2);
		tick(1);
		chk("ret_gap", take, 1'b0);
		serve(3'h5);
		chk("take_count", takes, 3);
		$display("test priority done");
		io_wr(cis_pkg::IO_STATUS, 8'h00);
		ev = 8'h40;
		tick(1);
		ev = 8'h00;
		tick(6);
		chk("level_forgot", flags[6], 1'b0);
		io_wr(cis_pkg::IO_STATUS, 8'h80);
		tick(4);
		chk("level_none", takes, 3);
		ev = 8'h40;
		serve(3'h6);
		tick(2);
		en = 8'hff;
		dis_p = 1'b1;
		tick(1);
		dis_p = 1'b0;
		tick(3);
		chk("cli_same", takes, 4);
		chk("cli_gie", status[7], 1'b0);
		io_wr(cis_pkg::IO_STATUS, 8'h80);
		serve(3'h7);
		$display("test level and disable done");
		sp1 = sp;
		sleep = 1'b1;
		wake = 1'b0;
		ev = 8'h10;
		tick(1);
		ev = 8'h00;
		n = 0;
		while (take !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		if (n == 40)
			bad_count++;
		chk("wake_vec", vec, 3'h4);
		sleep = 1'b0;
		tick(3);
		chk("wake_wait", hold, 1'b1);
		chk("wake_sp", sp, sp1);
		wake = 1'b1;
		tick(7);
		chk("wake_hold", hold, 1'b1);
		tick(1);
		chk("wake_end", hold, 1'b0);
		chk("wake_push", sp, sp1 - cis_pkg::RET_ADDR_BYTES);
		ret_p = 1'b1;
		tick(1);
		ret_p = 1'b0;
		tick(3);
		chk("wake_ret", sp, sp1);
		$display("test sleep entry done");
		give_verdict();
	end
endmodule
`default_nettype wire
